// File: src/pms_pkg.sv
/*
  Constants for the proportional / PI mode switch selector.
  Assumes reference and feedback magnitudes arrive already scaled to the
  units of the matching switching level, synchronous to sys_clk.
*/
// Function
// - Torque at or above level gives P
// - Rotary speed reference at level gives P
// - Linear speed level, 1 mm/s, 0..10000
// - Rotary acceleration at level gives P
// - Linear acceleration level 0..30000 gives P
// - Deviation at or above level gives P
// - Deviation condition only in position control
// - Deviation level 0..10000, default 0, immediate
// - Position integral time 0..50000, 0.1 ms
// - Select digit 0 torque..4 none
// - Rotary speed/accel levels ranges, default 0
package pms_pkg;
  localparam int unsigned TORQUE_LEVEL_DEFAULT = 32'hc8;
  localparam int unsigned TORQUE_LEVEL_MAX = 32'h320;
  localparam int unsigned SPEED_LEVEL_MAX = 32'h2710;
  localparam int unsigned ACCEL_LEVEL_MAX = 32'h7530;
  localparam int unsigned DEVIATION_LEVEL_MAX = 32'h2710;
  localparam int unsigned INTEGRAL_TIME_MAX = 32'hc350;
  localparam int unsigned LEVEL_DEFAULT = 32'h0;
  localparam int unsigned INTEGRAL_TIME_DEFAULT = 32'h0;
  // Integral time unit 0.1 ms expressed in ns, converted with the 40 ns clock
  localparam int unsigned INTEGRAL_UNIT_NS = 32'h186a0;
  localparam int unsigned CLK_PERIOD_NS = 32'h28;
  localparam int unsigned INTEGRAL_UNIT_CYCLES = INTEGRAL_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    PMS_SEL_TORQUE = 3'h0,
    PMS_SEL_SPEED = 3'h1,
    PMS_SEL_ACCEL = 3'h2,
    PMS_SEL_DEVIATION = 3'h3,
    PMS_SEL_NONE = 3'h4
  } pms_sel_t;
endpackage

// File: src/pms_level_compare.sv
/*
  Saturating level compare: clamps a level to its legal range and flags
  a magnitude at or above it, registered.
  Assumes magnitude and level are unsigned and on sys_clk.
*/
module pms_level_compare #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned LEVEL_MAX = 10000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] magnitude,
  input wire logic [WIDTH-1:0] level,
  output logic at_or_above
);
  localparam logic [WIDTH-1:0] LMAX = WIDTH'(LEVEL_MAX);
  logic next_at_or_above;
  logic [WIDTH-1:0] eff_level;
  always_comb begin
    // Out-of-range settings behave as the top of the range
    eff_level = (level > LMAX) ? LMAX : level;
    next_at_or_above = (magnitude >= eff_level);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      at_or_above <= 1'b0;
    end else begin
      at_or_above <= next_at_or_above;
    end
  end
endmodule // pms_level_compare

// File: src/pms_mode_switch.sv
/*
  Selects P or PI speed-loop control from the chosen reference quantity,
  and runs the position-loop integral time base.
  Assumes all inputs come from logic on sys_clk; signed quantities are
  compared by magnitude.
*/
module pms_mode_switch #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned TIME_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] switch_condition_select,
  input wire logic linear_motor,
  input wire logic position_control,
  input wire logic [WIDTH-1:0] torque_switch_level,
  input wire logic [WIDTH-1:0] rotary_speed_switch_level,
  input wire logic [WIDTH-1:0] rotary_accel_switch_level,
  input wire logic [WIDTH-1:0] linear_speed_switch_level,
  input wire logic [WIDTH-1:0] linear_accel_switch_level,
  input wire logic [WIDTH-1:0] deviation_switch_level,
  input wire logic [TIME_WIDTH-1:0] position_integral_time,
  input wire logic signed [WIDTH-1:0] torque_reference,
  input wire logic signed [WIDTH-1:0] speed_reference,
  input wire logic signed [WIDTH-1:0] accel_reference,
  input wire logic signed [WIDTH-1:0] position_deviation,
  input wire logic integral_clear,
  output logic p_control,
  output logic integral_enable,
  output logic integral_step
);
  // Channel order of the level compare bank
  localparam int CHANNELS = 32'h6;
  localparam int CH_TORQUE = 32'h0;
  localparam int CH_RSPEED = 32'h1;
  localparam int CH_LSPEED = 32'h2;
  localparam int CH_RACCEL = 32'h3;
  localparam int CH_LACCEL = 32'h4;
  localparam int CH_DEVIATION = 32'h5;

  localparam logic [TIME_WIDTH-1:0] TIME_MAX = TIME_WIDTH'(pms_pkg::INTEGRAL_TIME_MAX);
  localparam logic [15:0] UNIT_LAST = 16'(pms_pkg::INTEGRAL_UNIT_CYCLES - 1);

  logic signed [WIDTH-1:0] chan_ref [CHANNELS];
  logic [WIDTH-1:0] chan_level [CHANNELS];
  logic [CHANNELS-1:0] chan_hit;
  logic [2:0] held_sel;
  logic [2:0] next_held_sel;
  logic next_p_control;
  logic [TIME_WIDTH-1:0] eff_time;
  logic time_run;
  logic next_integral_enable;
  logic [15:0] unit_cnt;
  logic [15:0] next_unit_cnt;
  logic unit_done;
  logic [TIME_WIDTH-1:0] units;
  logic [TIME_WIDTH-1:0] units_inc;
  logic [TIME_WIDTH-1:0] next_units;
  logic next_integral_step;

  // The most negative input still yields its true magnitude, read unsigned
  function automatic logic [WIDTH-1:0] absval(input logic signed [WIDTH-1:0] v);
    absval = v[WIDTH-1] ? WIDTH'(-v) : v;
  endfunction

  function automatic int unsigned chan_level_max(input int ch);
    case (ch)
      CH_TORQUE: chan_level_max = pms_pkg::TORQUE_LEVEL_MAX;
      CH_RSPEED, CH_LSPEED: chan_level_max = pms_pkg::SPEED_LEVEL_MAX;
      CH_RACCEL, CH_LACCEL: chan_level_max = pms_pkg::ACCEL_LEVEL_MAX;
      default: chan_level_max = pms_pkg::DEVIATION_LEVEL_MAX;
    endcase
  endfunction

  // Speed and acceleration each feed a rotary and a linear compare; the copy
  // costs area but a change of motor type needs no refill of the compare
  always_comb begin
    chan_ref[CH_TORQUE] = torque_reference;
    chan_ref[CH_RSPEED] = speed_reference;
    chan_ref[CH_LSPEED] = speed_reference;
    chan_ref[CH_RACCEL] = accel_reference;
    chan_ref[CH_LACCEL] = accel_reference;
    chan_ref[CH_DEVIATION] = position_deviation;
    chan_level[CH_TORQUE] = torque_switch_level;
    chan_level[CH_RSPEED] = rotary_speed_switch_level;
    chan_level[CH_LSPEED] = linear_speed_switch_level;
    chan_level[CH_RACCEL] = rotary_accel_switch_level;
    chan_level[CH_LACCEL] = linear_accel_switch_level;
    chan_level[CH_DEVIATION] = deviation_switch_level;
  end

  // One saturating compare per channel, each registered
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      logic [WIDTH-1:0] mag;

      always_comb begin
        mag = absval(chan_ref[i]);
      end

      pms_level_compare #(
        .WIDTH(WIDTH),
        .LEVEL_MAX(chan_level_max(i))
      ) u_compare (
        .sys_clk(sys_clk),
        .rst(rst),
        .magnitude(mag),
        .level(chan_level[i]),
        .at_or_above(chan_hit[i])
      );
    end
  endgenerate

  // Select is registered alongside the compares so both align in time
  always_comb begin
    next_held_sel = switch_condition_select;
    next_p_control = 1'b0;
    case (held_sel)
      pms_pkg::PMS_SEL_TORQUE: begin
        next_p_control = chan_hit[CH_TORQUE];
      end
      pms_pkg::PMS_SEL_SPEED: begin
        if (linear_motor) begin
          next_p_control = chan_hit[CH_LSPEED];
        end else begin
          next_p_control = chan_hit[CH_RSPEED];
        end
      end
      pms_pkg::PMS_SEL_ACCEL: begin
        if (linear_motor) begin
          next_p_control = chan_hit[CH_LACCEL];
        end else begin
          next_p_control = chan_hit[CH_RACCEL];
        end
      end
      pms_pkg::PMS_SEL_DEVIATION: begin
        next_p_control = chan_hit[CH_DEVIATION] & position_control;
      end
      pms_pkg::PMS_SEL_NONE: begin
        next_p_control = 1'b0;
      end
      default: begin
        // Undefined digits act as no switching
        next_p_control = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held_sel <= pms_pkg::PMS_SEL_TORQUE;
      p_control <= 1'b0;
    end else begin
      held_sel <= next_held_sel;
      p_control <= next_p_control;
    end
  end

  // Position integral time base: one step per integral time constant.
  // Out-of-range settings act as the longest time; zero turns it off.
  always_comb begin
    eff_time = position_integral_time;
    if (position_integral_time > TIME_MAX) begin
      eff_time = TIME_MAX;
    end
    next_integral_enable = (eff_time != '0);
    time_run = next_integral_enable && !integral_clear;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      integral_enable <= 1'b0;
    end else begin
      integral_enable <= next_integral_enable;
    end
  end

  // Unit counter: one tick per 0.1 ms time unit, counted in sys_clk periods
  always_comb begin
    next_unit_cnt = unit_cnt + 16'h1;
    unit_done = 1'b0;
    if (!time_run) begin
      next_unit_cnt = 16'h0;
    end else if (unit_cnt == UNIT_LAST) begin
      next_unit_cnt = 16'h0;
      unit_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unit_cnt <= 16'h0;
    end else begin
      unit_cnt <= next_unit_cnt;
    end
  end

  // Compare with >= so lowering the time mid-count still fires once
  always_comb begin
    units_inc = units + 1'b1;
    next_units = units;
    next_integral_step = 1'b0;
    if (!time_run) begin
      next_units = '0;
    end else if (unit_done) begin
      if (units_inc >= eff_time) begin
        next_units = '0;
        next_integral_step = 1'b1;
      end else begin
        next_units = units_inc;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      units <= '0;
      integral_step <= 1'b0;
    end else begin
      units <= next_units;
      integral_step <= next_integral_step;
    end
  end
endmodule // pms_mode_switch

// File: sim/pms_loop_model.sv
/* Position loop stand-in that counts integral steps. Assumes the sys_clk domain. */
module pms_loop_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic integral_step,
  output logic [15:0] step_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wraps silently; runs stay far below the limit
  always_ff @(posedge sys_clk) begin
    step_count <= rst ? 16'h0 : step_count + 16'(integral_step);
  end
endmodule // pms_loop_model

// File: sim/pms_mode_switch_monitor.sv
/* Port assertions for the mode switch. Assumes binding onto pms_mode_switch. */
module pms_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linear_motor,
  input wire logic position_control,
  input wire logic p_control,
  input wire logic integral_enable,
  input wire logic integral_step,
  input wire logic [2:0] switch_condition_select,
  input wire logic [15:0] torque_switch_level,
  input wire logic [15:0] rotary_speed_switch_level,
  input wire logic [15:0] rotary_accel_switch_level,
  input wire logic [15:0] linear_speed_switch_level,
  input wire logic [15:0] linear_accel_switch_level,
  input wire logic [15:0] deviation_switch_level,
  input wire logic [15:0] position_integral_time,
  input wire logic signed [15:0] torque_reference,
  input wire logic signed [15:0] speed_reference,
  input wire logic signed [15:0] accel_reference,
  input wire logic signed [15:0] position_deviation
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  function automatic logic [15:0] mag(logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction
  // Levels above their clamp are left out, the design saturates them
  wire [2:0] s = switch_condition_select;
  wire tq = mag(torque_reference) >= torque_switch_level && torque_switch_level <= 16'h320;
  wire rs = mag(speed_reference) >= rotary_speed_switch_level && rotary_speed_switch_level <= 16'h2710;
  wire ls = mag(speed_reference) >= linear_speed_switch_level && linear_speed_switch_level <= 16'h2710;
  wire dv = mag(position_deviation) >= deviation_switch_level && deviation_switch_level <= 16'h2710;
  wire ra = mag(accel_reference) >= rotary_accel_switch_level && rotary_accel_switch_level <= 16'h7530;
  wire la = mag(accel_reference) >= linear_accel_switch_level && linear_accel_switch_level <= 16'h7530;
  torque_p_a: assert property ((s == 3'h0 && tq)[*3] |-> p_control)
    else $error("torque level missed");
  rotary_speed_a: assert property ((s == 3'h1 && !linear_motor && rs)[*3] |-> p_control)
    else $error("rotary speed level missed");
  linear_speed_a: assert property ((s == 3'h1 && linear_motor && ls)[*3] |-> p_control)
    else $error("linear speed level missed");
  rotary_accel_a: assert property ((s == 3'h2 && !linear_motor && ra)[*3] |-> p_control)
    else $error("rotary acceleration level missed");
  linear_accel_a: assert property ((s == 3'h2 && linear_motor && la)[*3] |-> p_control)
    else $error("linear acceleration level missed");
  deviation_p_a: assert property ((s == 3'h3 && position_control && dv)[*3] |-> p_control)
    else $error("deviation level missed");
  deviation_gate_a: assert property ((s == 3'h3 && !position_control)[*3] |-> !p_control)
    else $error("deviation used outside position control");
  no_switch_a: assert property ((s == 3'h4)[*3] |-> !p_control)
    else $error("switching while disabled");
  torque_pi_a: assert property ((s == 3'h0 && !tq && torque_switch_level <= 16'h320)[*3] |-> !p_control)
    else $error("no return to pi");
  integral_on_a: assert property (!$past(rst) |-> integral_enable == ($past(position_integral_time) != 16'h0))
    else $error("integral enable wrong");
  step_pulse_a: assert property (integral_step |=> !integral_step)
    else $error("integral step too long");
  cover property ($rose(p_control));
  cover property ($fell(p_control));
  cover property (integral_step);
endmodule // pms_monitor
bind pms_mode_switch pms_monitor mon (.sys_clk, .rst, .linear_motor, .position_control, .p_control,
  .integral_enable, .integral_step, .switch_condition_select, .torque_switch_level, .rotary_speed_switch_level,
  .rotary_accel_switch_level, .linear_speed_switch_level, .linear_accel_switch_level, .deviation_switch_level,
  .position_integral_time, .torque_reference, .speed_reference, .accel_reference, .position_deviation);

// File: sim/pms_mode_switch_tb.sv
/* Self-checking bench for the mode switch. Assumes the package and the loop model. */
module pms_mode_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, lin = 1'b0, pc = 1'b1, clr = 1'b0, p_control, integral_enable, integral_step;
  logic [2:0] sel = 3'h0;
  logic [15:0] itime = 16'(pms_pkg::INTEGRAL_TIME_DEFAULT), steps, snap;
  logic [15:0] lv [6] = '{16'(pms_pkg::TORQUE_LEVEL_DEFAULT), 16'h012c, 16'h0190, 16'h01f4, 16'h0258, 16'h02bc};
  logic signed [15:0] rf [4] = '{default: 16'h0};
  int errors = 0, checked = 0;
  pms_mode_switch DUT (.sys_clk, .rst, .switch_condition_select(sel), .linear_motor(lin), .position_control(pc),
    .torque_switch_level(lv[0]), .rotary_speed_switch_level(lv[1]), .rotary_accel_switch_level(lv[2]),
    .linear_speed_switch_level(lv[3]), .linear_accel_switch_level(lv[4]), .deviation_switch_level(lv[5]),
    .position_integral_time(itime), .torque_reference(rf[0]), .speed_reference(rf[1]), .accel_reference(rf[2]),
    .position_deviation(rf[3]), .integral_clear(clr), .p_control, .integral_enable, .integral_step);
  pms_loop_model loop (.sys_clk, .rst, .integral_step, .step_count(steps));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Unselected references sit above every level, so a wrong source shows up as P
  task automatic run(input logic [2:0] s, input logic l, input logic p, input int d);
    int li;
    logic want;
    li = s > 3'h3 ? 0 : s == 3'h0 ? 0 : s == 3'h3 ? 5 : int'(s) + 2 * int'(l);
    want = s < 3'h4 && d == 0 && (s != 3'h3 || p);
    @(negedge sys_clk);
    sel = s;
    lin = l;
    pc = p;
    for (int i = 0; i < 4; i++) begin
      rf[i] = (i == int'(s[1:0])) ? 16'((int'(lv[li]) + d) * (s[0] ? -1 : 1)) : 16'h7fff;
    end
    repeat (3) @(negedge sys_clk);
    check("p_control", 16'(p_control), 16'(want));
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check("p_control", 16'(p_control), 16'h0);
    for (int s = 0; s < 6; s++) begin
      run(3'(s), 1'b0, 1'b1, 0);
      run(3'(s), 1'b1, 1'b1, -1);
      run(3'(s), 1'b1, 1'b1, 0);
      run(3'(s), 1'b0, 1'b1, -1);
    end
    run(3'h3, 1'b0, 1'b0, 0);
    lv[5] = 16'(pms_pkg::LEVEL_DEFAULT);
    run(3'h3, 1'b0, 1'b1, 0);
    clr = 1'b1;
    itime = 16'h1;
    repeat (2) @(negedge sys_clk);
    check("integral_enable", 16'(integral_enable), 16'h1);
    snap = steps;
    clr = 1'b0;
    repeat (2 * pms_pkg::INTEGRAL_UNIT_CYCLES + 20) @(negedge sys_clk);
    check("integral steps", steps - snap, 16'h2);
    itime = 16'h0;
    snap = steps;
    repeat (pms_pkg::INTEGRAL_UNIT_CYCLES + 20) @(negedge sys_clk);
    check("integral_enable", 16'(integral_enable), 16'h0);
    check("integral steps", steps - snap, 16'h0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
endmodule // pms_mode_switch_tb
